/* File: hw/dp_status_pkg.sv */
// Constants for the debug port control/status and link control block.
// Assumes register offsets, bank values and field positions as printed.
package dp_status_pkg;
  localparam logic [3:0] CTRL_STATUS_OFFSET = 4'h4;
  localparam logic [3:0] LINK_CTRL_OFFSET   = 4'h4;
  localparam logic [3:0] BANK_CTRL_STATUS   = 4'h0;
  localparam logic [3:0] BANK_LINK_CTRL     = 4'h1;

  localparam int OVR_EN_BIT    = 0;
  localparam int OVR_FLAG_BIT  = 1;
  localparam int MODE_LSB      = 2;
  localparam int CMP_FLAG_BIT  = 4;
  localparam int ERR_FLAG_BIT  = 5;
  localparam int RDOK_BIT      = 6;
  localparam int LANE_LSB      = 8;
  localparam int TURN_LSB      = 8;
  localparam int LINK_RES1_BIT = 6;

  localparam logic       OVR_EN_RST = 1'b0;
  localparam logic       FLAG_RST   = 1'b0;
  localparam logic [1:0] MODE_RST   = 2'b00;
  localparam logic [3:0] LANE_RST   = 4'hf;
  localparam logic [1:0] TURN_RST   = 2'b00;

  localparam logic [1:0] MODE_NORMAL  = 2'b00;
  localparam logic [1:0] MODE_VERIFY  = 2'b01;
  localparam logic [1:0] MODE_COMPARE = 2'b10;

  localparam int EV_ERR    = 0;
  localparam int EV_CMP    = 1;
  localparam int EV_OVR    = 2;
  localparam int EV_RDOK   = 3;
  localparam int EV_RDFAIL = 4;
  localparam int EV_COUNT  = 5;

  typedef enum logic {ST_IDLE, ST_WAIT} core_state_t;
endpackage

/* File: hw/sync3.sv */
// Three-stage synchroniser for levels and toggles crossing into clk.
// Assumes each bit moves alone; multi-bit values must be quasi-static.
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
    end
  end
endmodule // sync3
`default_nettype wire

/* File: hw/sticky_flag.sv */
// One sticky status flag with set, clear and set-over-clear priority.
// Assumes set and clear are one-cycle pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  import dp_status_pkg::*;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= FLAG_RST;
    end else begin
      q <= set | (q & ~clr);
    end
  end
endmodule // sticky_flag
`default_nettype wire

/* File: hw/dp_status_flags.sv */
// Debug port control/status flags, transfer mode engine and link control.
// Assumes register access arrives on link_clk from the serial engine and
// access port traffic runs on clk; the two clocks are unrelated.
//
// Notes on behaviour
// - Read-ok flag shows whether the latest port read, or buffer read outside a response cycle, was OK.
// - Read-ok reads zero on the scan-chain port; read-only elsewhere.
// - Error flag sets on any port error and stays until cleared.
// - Early scan-chain port clears flags by writing ones; abort clear also works.
// - Otherwise error flag ignores writes; abort error-clear field clears it.
// - Compare flag sets on mismatch in compare mode, match in verify mode.
// - Otherwise compare flag ignores writes; abort compare-clear field clears it.
// - Two-bit transfer mode: normal, pushed-verify, pushed-compare, one reserved.
// - Normal mode passes each port transaction through with no comparison.
// - Pushed modes turn a write into a read and compare the result.
// - Overruns set the overrun flag only while detection is enabled.
// - Otherwise overrun flag ignores writes; abort overrun-clear field clears it.
// - Detection enable bit is read-write; one enables, zero disables.
// - After reset all flags and detection enable read zero.
// - Control/status sits at offset 0x4 in bank 0x0; low address bits zero.
// - Link control reads zero on scan-chain port; two-wire port upper bits zero.
// - Turnaround field sets one to four bit periods; resets to zero.
// - Lane mask picks which bytes take part in pushed comparisons.
`timescale 1ns/10ps
`default_nettype none
module dp_status_flags #(
  parameter bit SCAN_CHAIN = 1'b0,
  parameter bit ARCH_V1    = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        link_clk,
  // Register access, link_clk domain
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [3:0]  bank_sel,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        abort_wr,
  input  wire logic        abort_err_clr,
  input  wire logic        abort_cmp_clr,
  input  wire logic        abort_ovr_clr,
  input  wire logic        line_reset,
  output logic      [1:0]  turnaround_period,
  // Transaction side, clk domain
  input  wire logic        tr_valid,
  input  wire logic        tr_write,
  input  wire logic [7:0]  tr_addr,
  input  wire logic [31:0] tr_wdata,
  output logic             tr_busy,
  input  wire logic        buf_rd,
  input  wire logic        buf_rd_ok,
  output logic             ap_req_valid,
  output logic             ap_req_write,
  output logic      [7:0]  ap_req_addr,
  output logic      [31:0] ap_req_wdata,
  input  wire logic        ap_resp_valid,
  input  wire logic        ap_resp_err,
  input  wire logic [31:0] ap_resp_rdata,
  output logic             rd_valid,
  output logic      [31:0] rd_data
);
  import dp_status_pkg::*;

  // Write-one-to-clear only on the earliest scan-chain variant
  localparam bit W1C = SCAN_CHAIN && !ARCH_V1;

  logic [1:0] core_rst_reg;
  logic [1:0] link_rst_reg;
  logic       core_rst_n;
  logic       link_rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_rst_reg <= 2'b00;
    end else begin
      core_rst_reg <= {core_rst_reg[0], 1'b1};
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_rst_reg <= 2'b00;
    end else begin
      link_rst_reg <= {link_rst_reg[0], 1'b1};
    end
  end

  assign core_rst_n = core_rst_reg[1];
  assign link_rst_n = link_rst_reg[1];

  // Link domain: registers
  logic                ovr_en_reg;
  logic [1:0]          mode_reg;
  logic [3:0]          lane_reg;
  logic                rdok_reg;
  logic                err_flag;
  logic                cmp_flag;
  logic                ovr_flag;
  logic [EV_COUNT-1:0] ev_q;
  logic [EV_COUNT-1:0] ev_tgl_reg;
  logic [EV_COUNT-1:0] ev_seen_reg;
  logic [EV_COUNT-1:0] ev_pulse;
  logic                wr_cs;
  logic                wr_lc;
  logic                rd_cs;
  logic                rd_lc;
  logic                err_clr;
  logic                cmp_clr;
  logic                ovr_clr;
  logic [31:0]         cs_view;
  logic [31:0]         lc_view;

  assign wr_cs = reg_wr && reg_addr == CTRL_STATUS_OFFSET && bank_sel == BANK_CTRL_STATUS;
  assign rd_cs = reg_rd && reg_addr == CTRL_STATUS_OFFSET && bank_sel == BANK_CTRL_STATUS;
  assign wr_lc = reg_wr && reg_addr == LINK_CTRL_OFFSET && bank_sel == BANK_LINK_CTRL;
  assign rd_lc = reg_rd && reg_addr == LINK_CTRL_OFFSET && bank_sel == BANK_LINK_CTRL;

  // Events from the core arrive as toggles
  sync3 #(
    .W (EV_COUNT)
  ) u_ev_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (ev_tgl_reg),
    .q     (ev_q)
  );

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ev_seen_reg <= '0;
    end else begin
      ev_seen_reg <= ev_q;
    end
  end

  assign ev_pulse = ev_q ^ ev_seen_reg;

  // Abort clears on every variant; early scan chain lets the error clear take all
  assign err_clr = (W1C && wr_cs && reg_wdata[ERR_FLAG_BIT])
                 || (abort_wr && abort_err_clr);
  assign cmp_clr = (W1C && wr_cs && reg_wdata[CMP_FLAG_BIT])
                 || (abort_wr && (abort_cmp_clr || (W1C && abort_err_clr)));
  assign ovr_clr = (W1C && wr_cs && reg_wdata[OVR_FLAG_BIT])
                 || (abort_wr && (abort_ovr_clr || (W1C && abort_err_clr)));

  sticky_flag u_err_flag (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .set   (ev_pulse[EV_ERR]),
    .clr   (err_clr),
    .q     (err_flag)
  );

  sticky_flag u_cmp_flag (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .set   (ev_pulse[EV_CMP]),
    .clr   (cmp_clr),
    .q     (cmp_flag)
  );

  sticky_flag u_ovr_flag (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .set   (ev_pulse[EV_OVR] && ovr_en_reg),
    .clr   (ovr_clr),
    .q     (ovr_flag)
  );

  // Read-ok follows the latest outcome; never written by the probe
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rdok_reg <= FLAG_RST;
    end else if (ev_pulse[EV_RDOK]) begin
      rdok_reg <= 1'b1;
    end else if (ev_pulse[EV_RDFAIL]) begin
      rdok_reg <= 1'b0;
    end
  end

  // Mode reset is defined here although software must not rely on it
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ovr_en_reg <= OVR_EN_RST;
      mode_reg   <= MODE_RST;
      lane_reg   <= LANE_RST;
    end else if (wr_cs) begin
      ovr_en_reg <= reg_wdata[OVR_EN_BIT];
      mode_reg   <= reg_wdata[MODE_LSB +: 2];
      lane_reg   <= reg_wdata[LANE_LSB +: 4];
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      turnaround_period <= TURN_RST;
    end else if (line_reset) begin
      turnaround_period <= TURN_RST;
    end else if (wr_lc && !SCAN_CHAIN) begin
      turnaround_period <= reg_wdata[TURN_LSB +: 2];
    end
  end

  always_comb begin
    cs_view                   = 32'h0000_0000;
    cs_view[OVR_EN_BIT]       = ovr_en_reg;
    cs_view[OVR_FLAG_BIT]     = ovr_flag;
    cs_view[MODE_LSB +: 2]    = mode_reg;
    cs_view[CMP_FLAG_BIT]     = cmp_flag;
    cs_view[ERR_FLAG_BIT]     = err_flag;
    cs_view[RDOK_BIT]         = rdok_reg && !SCAN_CHAIN;
    cs_view[LANE_LSB +: 4]    = lane_reg;
    lc_view                   = 32'h0000_0000;
    if (!SCAN_CHAIN) begin
      lc_view[TURN_LSB +: 2]  = turnaround_period;
      lc_view[LINK_RES1_BIT]  = 1'b1;
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (rd_cs) begin
      reg_rdata <= cs_view;
    end else if (rd_lc) begin
      reg_rdata <= lc_view;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Core domain: transfer engine
  logic [5:0]          cfg_q;
  logic [1:0]          core_mode;
  logic [3:0]          core_lane;
  core_state_t         state_reg;
  logic                pushed_reg;
  logic                was_read_reg;
  logic [31:0]         held_reg;
  logic [EV_COUNT-1:0] ev_flip;
  logic                pushed;
  logic [3:0]          lane_diff;
  logic                masked_match;

  // Mode and mask change rarely; each bit settles on its own
  sync3 #(
    .W (6)
  ) u_cfg_sync (
    .clk   (clk),
    .rst_n (core_rst_n),
    .d     ({lane_reg, mode_reg}),
    .q     (cfg_q)
  );

  assign core_mode = cfg_q[1:0];
  assign core_lane = cfg_q[5:2];
  // Reserved mode code behaves as normal
  assign pushed = core_mode == MODE_VERIFY || core_mode == MODE_COMPARE;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_diff[i] = core_lane[i]
                   && (ap_resp_rdata[8*i +: 8] != held_reg[8*i +: 8]);
    end
  end

  assign masked_match = lane_diff == 4'h0;

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_reg    <= ST_IDLE;
      tr_busy      <= 1'b0;
      ap_req_valid <= 1'b0;
      ap_req_write <= 1'b0;
      ap_req_addr  <= 8'h00;
      ap_req_wdata <= 32'h0000_0000;
      pushed_reg   <= 1'b0;
      was_read_reg <= 1'b0;
      held_reg     <= 32'h0000_0000;
    end else begin
      ap_req_valid <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (tr_valid) begin
            state_reg    <= ST_WAIT;
            tr_busy      <= 1'b1;
            ap_req_valid <= 1'b1;
            ap_req_addr  <= tr_addr;
            ap_req_wdata <= tr_wdata;
            held_reg     <= tr_wdata;
            pushed_reg   <= tr_write && pushed;
            was_read_reg <= !tr_write;
            ap_req_write <= tr_write && !pushed;
          end
        end
        ST_WAIT: begin
          if (ap_resp_valid) begin
            state_reg <= ST_IDLE;
            tr_busy   <= 1'b0;
          end
        end
      endcase
    end
  end

  // A request while busy is an overrun and is dropped
  always_comb begin
    ev_flip            = '0;
    ev_flip[EV_OVR]    = tr_valid && state_reg == ST_WAIT;
    if (state_reg == ST_WAIT && ap_resp_valid) begin
      ev_flip[EV_ERR]    = ap_resp_err;
      ev_flip[EV_CMP]    = pushed_reg && !ap_resp_err
                         && ((core_mode == MODE_COMPARE && !masked_match)
                         || (core_mode == MODE_VERIFY && masked_match));
      ev_flip[EV_RDOK]   = was_read_reg && !ap_resp_err;
      ev_flip[EV_RDFAIL] = was_read_reg && ap_resp_err;
    end else if (buf_rd) begin
      ev_flip[EV_RDOK]   = buf_rd_ok;
      ev_flip[EV_RDFAIL] = !buf_rd_ok;
    end
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ev_tgl_reg <= '0;
    end else begin
      ev_tgl_reg <= ev_tgl_reg ^ ev_flip;
    end
  end

  // Pushed writes return no data to the probe
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end else begin
      rd_valid <= state_reg == ST_WAIT && ap_resp_valid && was_read_reg;
      if (state_reg == ST_WAIT && ap_resp_valid && was_read_reg) begin
        rd_data <= ap_resp_rdata;
      end
    end
  end
endmodule // dp_status_flags
`default_nettype wire

/* File: tb/dp_status_props.sv */
// Checker for the status flag block ports.
// Assumes binding into dp_status_flags; core and link clocks unrelated.
`timescale 1ns/10ps
`default_nettype none
module dp_status_props #(
  parameter bit SCAN_CHAIN = 1'b0
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        link_clk,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [3:0]  bank_sel,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        line_reset,
  input wire logic [1:0]  turnaround_period,
  input wire logic        tr_valid,
  input wire logic [7:0]  tr_addr,
  input wire logic        tr_busy,
  input wire logic        ap_req_valid,
  input wire logic [7:0]  ap_req_addr,
  input wire logic        ap_resp_valid,
  input wire logic [31:0] ap_resp_rdata,
  input wire logic        rd_valid,
  input wire logic [31:0] rd_data
);
  a_unmapped_zero: assert property (@(posedge link_clk) disable iff (!resetn)
    reg_rd && (reg_addr != 4'h4 || bank_sel > 4'h1) |=> reg_rdata == 32'h0) else $error("map");
  a_status_layout: assert property (@(posedge link_clk) disable iff (!resetn)
    reg_rd && reg_addr == 4'h4 && bank_sel == 4'h0 |=> reg_rdata[31:12] == 20'h0
    && !reg_rdata[7] && !(SCAN_CHAIN && reg_rdata[6])) else $error("status bits");
  a_link_layout: assert property (@(posedge link_clk) disable iff (!resetn)
    reg_rd && reg_addr == 4'h4 && bank_sel == 4'h1 |=> (SCAN_CHAIN ? reg_rdata == 32'h0
    : reg_rdata[31:10] == 22'h0 && reg_rdata[6])) else $error("link bits");
  a_turn_write: assert property (@(posedge link_clk) disable iff (!resetn)
    !SCAN_CHAIN && reg_wr && reg_addr == 4'h4 && bank_sel == 4'h1 && !line_reset
    |=> turnaround_period == $past(reg_wdata[9:8])) else $error("turn");
  a_turn_clear: assert property (@(posedge link_clk) disable iff (!resetn)
    line_reset |=> turnaround_period == 2'b00) else $error("line reset");
  a_req_issue: assert property (@(posedge clk) disable iff (!resetn)
    tr_valid && !tr_busy |=> ap_req_valid && tr_busy && ap_req_addr == $past(tr_addr))
    else $error("issue");
  a_req_single: assert property (@(posedge clk) disable iff (!resetn)
    ap_req_valid |=> !ap_req_valid) else $error("pulse");
  a_busy_refuse: assert property (@(posedge clk) disable iff (!resetn)
    tr_valid && tr_busy && !ap_resp_valid |=> !ap_req_valid) else $error("refuse");
  a_busy_drop: assert property (@(posedge clk) disable iff (!resetn)
    ap_resp_valid && tr_busy |=> !tr_busy) else $error("busy");
  a_rd_return: assert property (@(posedge clk) disable iff (!resetn)
    rd_valid |-> $past(ap_resp_valid) && rd_data == $past(ap_resp_rdata)) else $error("rd");
  c_overrun: cover property (@(posedge clk) disable iff (!resetn) tr_valid && tr_busy);
  c_read: cover property (@(posedge clk) disable iff (!resetn) rd_valid);
  c_line: cover property (@(posedge link_clk) disable iff (!resetn) line_reset);
endmodule // dp_status_props
bind dp_status_flags dp_status_props #(.SCAN_CHAIN(SCAN_CHAIN)) props_u (
  .clk(clk), .resetn(resetn), .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .bank_sel(bank_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .line_reset(line_reset), .turnaround_period(turnaround_period), .tr_valid(tr_valid),
  .tr_addr(tr_addr), .tr_busy(tr_busy), .ap_req_valid(ap_req_valid),
  .ap_req_addr(ap_req_addr), .ap_resp_valid(ap_resp_valid),
  .ap_resp_rdata(ap_resp_rdata), .rd_valid(rd_valid), .rd_data(rd_data));
`default_nettype wire

/* File: tb/ap_model.sv */
// Access port model behind the status block.
// Assumes one request at a time; slow stretches the answer.
`timescale 1ns/10ps
`default_nettype none
module ap_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        fail,
  input  wire logic        ap_req_valid,
  input  wire logic        ap_req_write,
  input  wire logic [7:0]  ap_req_addr,
  input  wire logic [31:0] ap_req_wdata,
  output logic             ap_resp_valid,
  output logic             ap_resp_err,
  output logic      [31:0] ap_resp_rdata
);
  logic [31:0] mem [256];
  logic [3:0]  wait_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 4'h0;
    end else if (ap_req_valid) begin
      wait_reg <= slow ? 4'h5 : 4'h1;
    end else if (wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (ap_req_valid && ap_req_write) begin
      mem[ap_req_addr] <= ap_req_wdata;
    end
  end
  // Data not held between answers, so a stale value cannot pass
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ap_resp_valid <= 1'b0;
      ap_resp_err   <= 1'b0;
      ap_resp_rdata <= 32'h0;
    end else begin
      ap_resp_valid <= wait_reg == 4'h1;
      ap_resp_err   <= wait_reg == 4'h1 && fail;
      ap_resp_rdata <= wait_reg == 4'h1 ? mem[ap_req_addr] : ~ap_resp_rdata;
    end
  end
endmodule // ap_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the status flag block, two-wire variant.
// Assumes the access port model answers on the core side.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dp_status_pkg::*;
  logic        clk, link_clk, resetn, reg_wr, reg_rd, abort_wr, a_err, a_cmp, a_ovr;
  logic        line_reset, tr_valid, tr_write, buf_rd, buf_rd_ok, slow, fail, tr_busy;
  logic        ap_req_valid, ap_req_write, ap_resp_valid, ap_resp_err, rd_valid;
  logic [1:0]  turn;
  logic [3:0]  reg_addr, bank_sel;
  logic [7:0]  tr_addr, ap_req_addr;
  logic [31:0] reg_wdata, reg_rdata, tr_wdata, ap_req_wdata, ap_resp_rdata, rd_data;
  int          n_mismatch, n_compared;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] NO_OK = 32'hffff_ffbf;
  // Pushed mode table: mode word, write data, status after, write kept
  logic [31:0] cfg_t [6] = '{32'h0f08, 32'h0f08, 32'h0f04, 32'h0f04, 32'h0108, 32'h0f0c};
  logic [31:0] dat_t [6] = '{32'h1111_2222, 32'ha5a5_0f0f, 32'ha5a5_0f0f, 32'h1111_2222,
                             32'h00a5_0f0f, 32'ha5a5_0f0f};
  logic [31:0] exp_t [6] = '{32'h0f18, 32'h0f08, 32'h0f14, 32'h0f04, 32'h0108, 32'h0f0c};
  logic        wrk_t [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  dp_status_flags dut_u (.clk(clk), .resetn(resetn), .link_clk(link_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .bank_sel(bank_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .abort_wr(abort_wr), .abort_err_clr(a_err),
    .abort_cmp_clr(a_cmp), .abort_ovr_clr(a_ovr), .line_reset(line_reset),
    .turnaround_period(turn), .tr_valid(tr_valid), .tr_write(tr_write), .tr_addr(tr_addr),
    .tr_wdata(tr_wdata), .tr_busy(tr_busy), .buf_rd(buf_rd), .buf_rd_ok(buf_rd_ok),
    .ap_req_valid(ap_req_valid), .ap_req_write(ap_req_write), .ap_req_addr(ap_req_addr),
    .ap_req_wdata(ap_req_wdata), .ap_resp_valid(ap_resp_valid), .ap_resp_err(ap_resp_err),
    .ap_resp_rdata(ap_resp_rdata), .rd_valid(rd_valid), .rd_data(rd_data));
  ap_model ap_u (.clk(clk), .resetn(resetn), .slow(slow), .fail(fail),
    .ap_req_valid(ap_req_valid), .ap_req_write(ap_req_write), .ap_req_addr(ap_req_addr),
    .ap_req_wdata(ap_req_wdata), .ap_resp_valid(ap_resp_valid), .ap_resp_err(ap_resp_err),
    .ap_resp_rdata(ap_resp_rdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  task automatic bad(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic cmp32(input logic [31:0] got, exp, msk, input string m);
    n_compared++;
    if (((got ^ exp) & msk) !== 32'h0) bad(m);
  endtask
  task automatic cmp_bit(input logic got, exp, input string m);
    n_compared++;
    if (got !== exp) bad(m);
  endtask
  task automatic reg_acc(input logic wr, input logic [3:0] bk, ad, input logic [31:0] d);
    @(posedge link_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    bank_sel <= bk;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge link_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge link_clk);
    #1;
  endtask
  // Long settle: flags cross from the core as toggles
  task automatic rd_chk(input logic [3:0] bk, ad, input logic [31:0] e, msk, input string m);
    repeat (12) @(posedge link_clk);
    reg_acc(1'b0, bk, ad, 32'h0);
    cmp32(reg_rdata, e, msk, m);
  endtask
  task automatic abort(input logic e, c, o);
    @(posedge link_clk);
    {abort_wr, a_err, a_cmp, a_ovr} <= {1'b1, e, c, o};
    @(posedge link_clk);
    {abort_wr, a_err, a_cmp, a_ovr} <= 4'h0;
  endtask
  task automatic tr_pulse(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {tr_valid, tr_write, tr_addr, tr_wdata} <= {1'b1, w, a, d};
    @(posedge clk);
    tr_valid <= 1'b0;
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      #1;
      if (tr_busy === 1'b0) break;
    end
    if (i == 30) bad("busy stuck");
  endtask
  task automatic xact(input logic w, input logic [7:0] a, input logic [31:0] d);
    tr_pulse(w, a, d);
    wait_idle();
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad("watchdog");
    close_out();
  end
  initial begin
    {resetn, reg_wr, reg_rd, abort_wr, a_err, a_cmp, a_ovr, line_reset} = 8'h0;
    {tr_valid, tr_write, buf_rd, buf_rd_ok, slow, fail} = 6'h0;
    {reg_addr, bank_sel, tr_addr, reg_wdata, tr_wdata} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(4'h0, CTRL_STATUS_OFFSET, 32'h0f00, ALL, "status reset");
    rd_chk(BANK_LINK_CTRL, 4'h4, 32'h0040, ALL, "link reset");
    rd_chk(4'h0, 4'h8, 32'h0, ALL, "unmapped offset");
    rd_chk(4'h2, 4'h4, 32'h0, ALL, "unmapped bank");
    reg_acc(1'b1, 4'h0, 4'h4, 32'h0f73);
    rd_chk(4'h0, 4'h4, 32'h0f01, ALL, "flag writes");
    $display("test reset and map done");
    xact(1'b1, 8'h10, 32'ha5a5_0f0f);
    cmp_bit(ap_req_write, 1'b1, "normal write");
    xact(1'b0, 8'h10, 32'h0);
    cmp32(rd_data, 32'ha5a5_0f0f, ALL, "normal read");
    rd_chk(4'h0, 4'h4, 32'h0f41, ALL, "read ok");
    @(posedge clk);
    {buf_rd, buf_rd_ok} <= 2'b10;
    @(posedge clk);
    buf_rd <= 1'b0;
    rd_chk(4'h0, 4'h4, 32'h0f01, ALL, "buffer not ok");
    @(posedge clk);
    fail <= 1'b1;
    xact(1'b0, 8'h10, 32'h0);
    fail <= 1'b0;
    rd_chk(4'h0, 4'h4, 32'h0f21, ALL, "error read");
    reg_acc(1'b1, 4'h0, 4'h4, 32'h0f21);
    rd_chk(4'h0, 4'h4, 32'h0f21, ALL, "error holds");
    abort(1'b1, 1'b0, 1'b0);
    rd_chk(4'h0, 4'h4, 32'h0f01, ALL, "error cleared");
    $display("test normal path done");
    slow <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      tr_pulse(1'b0, 8'h10, 32'h0);
      tr_pulse(1'b0, 8'h10, 32'h0);
      wait_idle();
      rd_chk(4'h0, 4'h4, k ? 32'h0f00 : 32'h0f03, NO_OK, "overrun");
      abort(1'b0, 1'b0, 1'b1);
      rd_chk(4'h0, 4'h4, k ? 32'h0f00 : 32'h0f01, NO_OK, "overrun clear");
      xact(1'b0, 8'h10, 32'h0);
      reg_acc(1'b1, 4'h0, 4'h4, {28'h0f0, MODE_NORMAL, 2'b00});
    end
    slow <= 1'b0;
    $display("test overrun done");
    for (int k = 0; k < 6; k++) begin
      reg_acc(1'b1, 4'h0, 4'h4, cfg_t[k]);
      // Mode and mask need time to cross into the core
      repeat (6) @(posedge clk);
      xact(1'b1, 8'h10, dat_t[k]);
      cmp_bit(ap_req_write, wrk_t[k], "pushed write");
      rd_chk(4'h0, 4'h4, exp_t[k], NO_OK, "compare flag");
      abort(1'b0, 1'b1, 1'b0);
    end
    rd_chk(4'h0, 4'h4, 32'h0f0c, NO_OK, "compare cleared");
    reg_acc(1'b1, 4'h0, 4'h4, 32'h0f00);
    repeat (6) @(posedge clk);
    xact(1'b0, 8'h10, 32'h0);
    cmp32(rd_data, 32'ha5a5_0f0f, ALL, "pushed stored");
    $display("test pushed modes done");
    reg_acc(1'b1, 4'h1, 4'h4, 32'h0300);
    rd_chk(4'h1, 4'h4, 32'h0340, ALL, "turnaround");
    cmp32({30'h0, turn}, 32'h3, ALL, "turn out");
    @(posedge link_clk);
    line_reset <= 1'b1;
    @(posedge link_clk);
    line_reset <= 1'b0;
    rd_chk(4'h1, 4'h4, 32'h0040, ALL, "line reset");
    $display("test link control done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
